// ---- adcc_pkg.sv ----
// Purpose: shared constants and types of the converter control and status block
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word
// Notes: only the low byte of each control word is used; results read 16 bits wide
package adcc_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned RES_W         = 10;
   localparam int unsigned RES_LSB       = 6;
   localparam int unsigned NUM_CH        = 8;
   // byte offsets
   localparam logic [7:0]  OFS_CSR       = 8'h00;
   localparam logic [7:0]  OFS_CR        = 8'h04;
   localparam logic [7:0]  OFS_RES0      = 8'h10;
   localparam logic [7:0]  OFS_RES_LAST  = 8'h2C;
   // field positions in the control/status word
   localparam int unsigned FLAG_BIT      = 7;
   localparam int unsigned IE_BIT        = 6;
   localparam int unsigned RUN_BIT       = 5;
   localparam int unsigned RSVD_BIT      = 4;
   // field positions in the control word
   localparam int unsigned MCE_BIT       = 5;
   localparam int unsigned GSS_BIT       = 4;
   localparam logic [7:0]  CSR_RESET     = 8'h00;
   localparam logic [1:0]  MODE_RESET    = 2'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic       conv_end_flag;
      logic       conv_end_irq_enable;
      logic       convert_run;
      logic       rsvd;
      logic [3:0] channel_select;
   } adcc_csr_t;

   typedef struct packed {
      logic multi_channel_enable;
      logic group_size_select;
   } adcc_mode_t;

   typedef enum {
      ADCC_IDLE,
      ADCC_START,
      ADCC_WAIT
   } adcc_state_t;
endpackage

// ---- adcc_ctrl.sv ----
// Purpose: control and status logic of an eight-input successive-approximation converter
// Assumes: analog datapath outside; it takes conv_start and answers with conv_done
// Notes: registers over AXI4-Lite; standby and module stop arrive on halt_req
// Function
// - Transfer-controller read of a result, while interrupt pending, clears end flag.
// - Interrupt request passes the end flag only while enable bit 6 is 1.
// - Writing run bit 5 to 0 halts conversion and returns to idle.
// - Writing run bit to 1 starts conversion on the selected channel or group.
// - Single mode: run bit clears itself when the channel finishes.
// - Scan mode: group repeats until run cleared by software, reset or halt.
// - Bit 4 is reserved: reads 0, writes ignored.
// - Four-bit channel select in bits 3..0, read/write, read with scan bits.
// - No scan: codes 0..7 pick inputs 0..7; top bit must stay 0.
// - Four-channel scan: inputs base..base+n, base 0 or 4, n low bits.
// - Eight-channel scan: code k converts inputs 0 through k.
// - End flag takes only a written 0; written 1 is ignored.
// - End flag sets on single conversion end or end of whole scan group.
// - Writing 0 to end flag after reading it as 1 clears it.
// - Scan bits: 0x single, 10 four-channel scan, 11 eight-channel scan.
// - Result words hold value in bits 15..6, zeros below.
`timescale 1ns/1ps
module adcc_ctrl #(
   parameter int unsigned AW = adcc_pkg::ADDR_W
) (
   // clock and reset
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   // write address and data
   input  wire logic [AW-1:0]                s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   // write response
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   // read
   input  wire logic [AW-1:0]                s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // analog converter
   output logic                              conv_start,
   output logic                              conv_abort,
   output logic [2:0]                        conv_channel,
   input  wire logic                         conv_done,
   input  wire logic [adcc_pkg::RES_W-1:0]   conv_result,
   // system
   input  wire logic                         halt_req,
   input  wire logic                         xfer_result_rd,
   output logic                              conv_end_interrupt
);

   adcc_pkg::adcc_csr_t   csr_q;
   adcc_pkg::adcc_mode_t  mode_q;
   adcc_pkg::adcc_state_t st_q;
   logic [2:0]            cur_q;
   logic                  seen_q;
   logic [adcc_pkg::RES_W-1:0] res_q [adcc_pkg::NUM_CH];
   logic                  aw_got_q, w_got_q;
   logic [AW-1:0]         awaddr_q;
   logic [31:0]           wdata_q;
   logic [3:0]            wstrb_q;
   logic [1:0]            bresp_q, rresp_q;
   logic                  bvalid_q, rvalid_q;
   logic [31:0]           rdata_q;

   // first channel of the group; the last is always select[2:0]
   function automatic logic [2:0] first_chan(input adcc_pkg::adcc_mode_t m, input logic [3:0] sel);
      if (!m.multi_channel_enable)
         first_chan = sel[2:0];
      else if (!m.group_size_select)
         first_chan = {sel[2], 2'h0};
      else
         first_chan = 3'h0;
   endfunction

   function automatic logic is_scan(input adcc_pkg::adcc_mode_t m);
      is_scan = m.multi_channel_enable;
   endfunction

   function automatic logic mapped(input logic [AW-1:0] a);
      mapped = (a == adcc_pkg::OFS_CSR) || (a == adcc_pkg::OFS_CR) ||
               (a >= adcc_pkg::OFS_RES0 && a <= adcc_pkg::OFS_RES_LAST && a[1:0] == 2'h0);
   endfunction

   // write channel: address and data may arrive in either order
   logic          aw_hs, w_hs, wr_fire, wr_ok, wr_csr, wr_cr;
   logic [AW-1:0] wa;
   logic [31:0]   wd;
   logic [3:0]    ws;
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready  = !w_got_q && !bvalid_q;
   assign aw_hs   = s_axi_awvalid && s_axi_awready;
   assign w_hs    = s_axi_wvalid && s_axi_wready;
   assign wr_fire = (aw_got_q || aw_hs) && (w_got_q || w_hs);
   assign wa      = aw_got_q ? awaddr_q : s_axi_awaddr;
   assign wd      = w_got_q ? wdata_q : s_axi_wdata;
   assign ws      = w_got_q ? wstrb_q : s_axi_wstrb;
   assign wr_ok   = wr_fire && mapped(wa);
   assign wr_csr  = wr_fire && wa == adcc_pkg::OFS_CSR && ws[0];
   assign wr_cr   = wr_fire && wa == adcc_pkg::OFS_CR && ws[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= '0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else begin
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
         end else begin
            if (aw_hs) aw_got_q <= 1'b1;
            if (w_hs) w_got_q <= 1'b1;
         end
         if (aw_hs) awaddr_q <= s_axi_awaddr;
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= adcc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // read channel: one cycle from address to data
   logic        ar_hs;
   logic [31:0] rd_word;
   logic [2:0]  ridx;
   assign s_axi_arready = !rvalid_q;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   assign ridx  = 3'((s_axi_araddr - adcc_pkg::OFS_RES0) >> 2);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (s_axi_araddr == adcc_pkg::OFS_CSR)
         rd_word[7:0] = {csr_q.conv_end_flag, csr_q.conv_end_irq_enable,
                         csr_q.convert_run, 1'b0, csr_q.channel_select};
      else if (s_axi_araddr == adcc_pkg::OFS_CR) begin
         rd_word[adcc_pkg::MCE_BIT] = mode_q.multi_channel_enable;
         rd_word[adcc_pkg::GSS_BIT] = mode_q.group_size_select;
      end else if (mapped(s_axi_araddr))
         rd_word[15:0] = {res_q[ridx], 6'h00};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= adcc_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= mapped(s_axi_araddr) ? adcc_pkg::RESP_OKAY : adcc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // conversion events
   logic       done_ok, grp_end;
   logic [2:0] first_c;
   assign first_c = first_chan(mode_q, csr_q.channel_select);
   assign done_ok = st_q == adcc_pkg::ADCC_WAIT && csr_q.convert_run && conv_done;
   assign grp_end = done_ok && cur_q == csr_q.channel_select[2:0];

   always_ff @(posedge aclk) begin
      if (!aresetn)
         mode_q <= adcc_pkg::MODE_RESET;
      else if (wr_cr)
         mode_q <= {wd[adcc_pkg::MCE_BIT], wd[adcc_pkg::GSS_BIT]};
   end

   // software sees the flag at 1 before it may clear it
   always_ff @(posedge aclk) begin
      if (!aresetn)
         seen_q <= 1'b0;
      else if (!csr_q.conv_end_flag)
         seen_q <= 1'b0;
      else if (ar_hs && s_axi_araddr == adcc_pkg::OFS_CSR)
         seen_q <= 1'b1;
   end

   logic flag_clr;
   assign flag_clr = (wr_csr && !wd[adcc_pkg::FLAG_BIT] && seen_q) ||
                     (xfer_result_rd && conv_end_interrupt);

   always_ff @(posedge aclk) begin
      if (!aresetn)
         csr_q <= adcc_pkg::CSR_RESET;
      else begin
         // set wins over any clear arriving in the same cycle
         if (grp_end)
            csr_q.conv_end_flag <= 1'b1;
         else if (flag_clr)
            csr_q.conv_end_flag <= 1'b0;
         if (wr_csr) begin
            csr_q.conv_end_irq_enable <= wd[adcc_pkg::IE_BIT];
            csr_q.channel_select      <= wd[3:0];
         end
         // halt beats software; software beats the self-clear
         if (halt_req)
            csr_q.convert_run <= 1'b0;
         else if (wr_csr)
            csr_q.convert_run <= wd[adcc_pkg::RUN_BIT];
         else if (grp_end && !is_scan(mode_q))
            csr_q.convert_run <= 1'b0;
         csr_q.rsvd <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q  <= adcc_pkg::ADCC_IDLE;
         cur_q <= 3'h0;
      end else begin
         case (st_q)
            adcc_pkg::ADCC_IDLE: begin
               cur_q <= first_c;
               if (csr_q.convert_run) st_q <= adcc_pkg::ADCC_START;
            end
            adcc_pkg::ADCC_START: begin
               st_q <= csr_q.convert_run ? adcc_pkg::ADCC_WAIT : adcc_pkg::ADCC_IDLE;
            end
            adcc_pkg::ADCC_WAIT: begin
               if (!csr_q.convert_run)
                  st_q <= adcc_pkg::ADCC_IDLE;
               else if (grp_end) begin
                  cur_q <= first_c;
                  st_q  <= is_scan(mode_q) ? adcc_pkg::ADCC_START : adcc_pkg::ADCC_IDLE;
               end else if (done_ok) begin
                  cur_q <= cur_q + 3'h1;
                  st_q  <= adcc_pkg::ADCC_START;
               end
            end
            default: st_q <= adcc_pkg::ADCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < adcc_pkg::NUM_CH; i++) res_q[i] <= '0;
      end else if (done_ok) begin
         res_q[cur_q] <= conv_result;
      end
   end

   assign conv_start         = st_q == adcc_pkg::ADCC_START && csr_q.convert_run;
   assign conv_abort         = st_q != adcc_pkg::ADCC_IDLE && !csr_q.convert_run;
   assign conv_channel       = cur_q;
   // level output; a stale flag with the enable off stays silent
   assign conv_end_interrupt = csr_q.conv_end_flag && csr_q.conv_end_irq_enable;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence stop_write_s;
      wr_csr && !wd[adcc_pkg::RUN_BIT] && !halt_req && st_q != adcc_pkg::ADCC_IDLE;
   endsequence
   sequence back_idle_s;
      !csr_q.convert_run ##1 st_q == adcc_pkg::ADCC_IDLE;
   endsequence

   flag_set_a: assert property (grp_end |=> csr_q.conv_end_flag)
      else $error("end flag not set at group end");
   single_clear_a: assert property (grp_end && !is_scan(mode_q) && !wr_csr && !halt_req |=>
      !csr_q.convert_run ##1 st_q == adcc_pkg::ADCC_IDLE)
      else $error("single mode run bit not self-cleared");
   scan_repeat_a: assert property (grp_end && is_scan(mode_q) && !wr_csr && !wr_cr && !halt_req |=>
      csr_q.convert_run && conv_start && conv_channel == first_c)
      else $error("scan group did not restart");
   stop_idle_a: assert property (stop_write_s |=> back_idle_s)
      else $error("halt write did not reach idle");
   start_chan_a: assert property ($rose(csr_q.convert_run) && st_q == adcc_pkg::ADCC_IDLE && !wr_cr && !wr_csr &&
      !halt_req |=>
      conv_start && conv_channel == $past(first_c))
      else $error("conversion not started on first channel");
   rsvd_zero_a: assert property (ar_hs && s_axi_araddr == adcc_pkg::OFS_CSR |=> !s_axi_rdata[adcc_pkg::RSVD_BIT])
      else $error("reserved bit read as one");
   xfer_clear_a: assert property (xfer_result_rd && conv_end_interrupt && !grp_end |=> !csr_q.conv_end_flag)
      else $error("transfer read did not clear flag");
   one_write_a: assert property (wr_csr && wd[adcc_pkg::FLAG_BIT] && !csr_q.conv_end_flag && !grp_end |=>
      !csr_q.conv_end_flag)
      else $error("written one set the end flag");
   sw_clear_a: assert property (wr_csr && !wd[adcc_pkg::FLAG_BIT] && seen_q && !grp_end |=> !csr_q.conv_end_flag)
      else $error("software clear ignored");
   irq_gate_a: assert property (!csr_q.conv_end_irq_enable || !csr_q.conv_end_flag |-> !conv_end_interrupt)
      else $error("interrupt without flag and enable");
   irq_hold_a: assert property (conv_end_interrupt && !flag_clr && !wr_csr |=> conv_end_interrupt)
      else $error("interrupt dropped while pending");
   res_fmt_a: assert property (ar_hs && s_axi_araddr >= adcc_pkg::OFS_RES0 |=> s_axi_rdata[5:0] == 6'h00)
      else $error("result low bits not zero");
endmodule

// ---- adcc_ctrl_tb_top.sv ----
// Purpose: self-checking bench of the converter control and status block
// Assumes: analog side modelled in the bench; conv_done answers each conv_start while auto_done is 1
// Notes: ordinary channel groups run from a table; flag, interrupt, stop and halt by hand
`timescale 1ns/1ps
module adcc_ctrl_tb_top;
   typedef struct {logic [1:0] mode; logic [3:0] sel; int first; int last;} adcc_row_t;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        conv_start, conv_abort, conv_done = 1'b0, halt_req = 1'b0, xfer_result_rd = 1'b0;
   logic [2:0]  conv_channel;
   logic [9:0]  conv_result = 10'h000;
   logic        conv_end_interrupt, auto_done = 1'b1;
   logic [31:0] rd;
   int          fails = 0, samples_checked = 0, cyc = 0, dly = 0, n, sz, aborts = 0;
   int          starts[$];
   adcc_row_t   rows[9] = '{'{2'b00, 4'h3, 3, 3}, '{2'b01, 4'h7, 7, 7}, '{2'b00, 4'h0, 0, 0},
                            '{2'b10, 4'h2, 0, 2}, '{2'b10, 4'h7, 4, 7}, '{2'b10, 4'h4, 4, 4},
                            '{2'b11, 4'h5, 0, 5}, '{2'b11, 4'h0, 0, 0}, '{2'b11, 4'h7, 0, 7}};

   adcc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_start(conv_start),
      .conv_abort(conv_abort), .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_result(conv_result), .halt_req(halt_req), .xfer_result_rd(xfer_result_rd),
      .conv_end_interrupt(conv_end_interrupt));

   always #4 aclk = ~aclk;

   function automatic logic [9:0] exp_res(input int ch);
      return 10'h2A5 + 10'(ch * 17);
   endfunction

   // analog side: logs each start, answers after a few cycles with a channel-coded value while auto_done is 1
   always @(posedge aclk) begin
      conv_done <= 1'b0;
      if (aresetn && conv_abort === 1'b1) aborts <= aborts + 1;
      if (aresetn && conv_start === 1'b1) begin
         starts.push_back(int'(conv_channel));
         conv_result <= exp_res(int'(conv_channel));
         dly = 3;
      end else if (dly > 0) begin
         dly = dly - 1;
         if (dly == 0 && auto_done) conv_done <= 1'b1;
      end
   end

   // cut a hang short; the longest path is well under this many cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         print_verdict();
      end
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw, w, b;
      aw = 1'b1;
      w = 1'b1;
      b = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w || b) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
         if (w && s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
         if (b && s_axi_bvalid) begin b = 1'b0; r = s_axi_bresp; s_axi_bready <= 1'b0; end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, rv;
      ar = 1'b1;
      rv = 1'b1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (ar || rv) begin
         @(posedge aclk);
         if (ar && s_axi_arready) begin ar = 1'b0; s_axi_arvalid <= 1'b0; end
         else if (!ar && s_axi_rvalid) begin rv = 1'b0; d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; end
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(adcc_pkg::OFS_CSR, rd, resp);
      chk_val(rd, {24'h0, adcc_pkg::CSR_RESET});
      axi_rd(adcc_pkg::OFS_CR, rd, resp);
      chk_val(rd, 32'h0);
      chk_bit(conv_end_interrupt, 1'b0);
      $display("test reset done");
      foreach (rows[i]) begin
         n = rows[i].last - rows[i].first + 1;
         starts.delete();
         axi_wr(adcc_pkg::OFS_CR, {2'b00, rows[i].mode, 4'h0}, resp);
         axi_wr(adcc_pkg::OFS_CSR, {4'h2, rows[i].sel}, resp);
         while (starts.size() < (rows[i].mode[1] ? n + 1 : 1)) @(posedge aclk);
         repeat (10) @(posedge aclk);
         if (!rows[i].mode[1]) chk_val(starts.size(), 1);
         for (int k = 0; k < (rows[i].mode[1] ? n + 1 : 1); k++)
            chk_val(starts[k], rows[i].first + (k % n));
         axi_rd(adcc_pkg::OFS_CSR, rd, resp);
         chk_val(rd, {24'h0, 1'b1, 1'b0, rows[i].mode[1], 1'b0, rows[i].sel});
         for (int c = rows[i].first; c <= rows[i].last; c++) begin
            axi_rd(8'(adcc_pkg::OFS_RES0 + 4 * c), rd, resp);
            chk_val(rd, {16'h0, exp_res(c), 6'h00});
         end
         axi_wr(adcc_pkg::OFS_CSR, 8'h80, resp);
         repeat (10) @(posedge aclk);
         axi_rd(adcc_pkg::OFS_CSR, rd, resp);
         chk_val(rd, 32'h80);
         axi_wr(adcc_pkg::OFS_CSR, 8'h00, resp);
         axi_rd(adcc_pkg::OFS_CSR, rd, resp);
         chk_val(rd, 32'h00);
         $display("test row %0d done", i);
      end
      axi_wr(adcc_pkg::OFS_CR, 8'h00, resp);
      axi_wr(adcc_pkg::OFS_CSR, 8'h9F, resp);
      axi_rd(adcc_pkg::OFS_CSR, rd, resp);
      chk_val(rd, 32'h0F);
      axi_wr(adcc_pkg::OFS_CSR, 8'h62, resp);
      repeat (12) @(posedge aclk);
      #1 chk_bit(conv_end_interrupt, 1'b1);
      axi_wr(adcc_pkg::OFS_CSR, 8'h82, resp);
      #1 chk_bit(conv_end_interrupt, 1'b0);
      axi_wr(adcc_pkg::OFS_CSR, 8'h42, resp);
      #1 chk_bit(conv_end_interrupt, 1'b1);
      @(posedge aclk) xfer_result_rd <= 1'b1;
      @(posedge aclk) xfer_result_rd <= 1'b0;
      #1 chk_bit(conv_end_interrupt, 1'b0);
      axi_rd(adcc_pkg::OFS_CSR, rd, resp);
      chk_val(rd, 32'h42);
      $display("test flag and interrupt done");
      axi_wr(8'h80, 8'h55, resp);
      chk_val(resp, adcc_pkg::RESP_SLVERR);
      axi_rd(8'h80, rd, resp);
      chk_val(rd, 32'h0);
      chk_val({30'h0, resp}, {30'h0, adcc_pkg::RESP_SLVERR});
      $display("test unmapped done");
      auto_done <= 1'b0;
      n = aborts;
      axi_wr(adcc_pkg::OFS_CSR, 8'h21, resp);
      repeat (5) @(posedge aclk);
      axi_wr(adcc_pkg::OFS_CSR, 8'h01, resp);
      #1 chk_val(aborts - n, 1);
      axi_rd(adcc_pkg::OFS_CSR, rd, resp);
      chk_val(rd, 32'h01);
      $display("test stop done");
      auto_done <= 1'b1;
      starts.delete();
      axi_wr(adcc_pkg::OFS_CR, 8'h30, resp);
      axi_wr(adcc_pkg::OFS_CSR, 8'h21, resp);
      while (starts.size() < 3) @(posedge aclk);
      halt_req <= 1'b1;
      repeat (4) @(posedge aclk);
      halt_req <= 1'b0;
      axi_rd(adcc_pkg::OFS_CSR, rd, resp);
      chk_bit(rd[adcc_pkg::RUN_BIT], 1'b0);
      sz = starts.size();
      repeat (20) @(posedge aclk);
      chk_val(starts.size(), sz);
      $display("test halt done");
      print_verdict();
   end
endmodule
